// [design/rx_parallel_output_interface.sv]
// Receive parallel output port: status, parity, clock select, reframe gate
//
// Function
// - Status outputs change only after a rising edge of the selected clock, except at reference half rate.
// - Decoder bypassed: status bits 1:0 carry character bits 1:0.
// - Decoder bypassed: status bit 2 high when held character is a comma.
// - Decoder enabled: status outputs report decoded character status.
// - Parity control not low: drive odd parity over the data bus.
// - Parity control low: parity output driver goes high impedance.
// - Source select mid: recovered clock out as true/complement pair.
// - Recovered mode: pair runs continuously at character or half rate.
// - Source select low: pair is buffered copy of the reference clock.
// - Delayed reference clock output enabled only when source select low.
// - Rate low: pair at character rate; host latches on true rise.
// - Rate high: pair at half rate; host latches on alternate rises.
// - Reference clocking ignores rate select; pair tracks reference clock.
// - Reframe enable high lets framer realign per mode and character.
// - Decoder bypassed: data bus carries character bits 9:2.
// - Reference half-rate: outputs change on both reference clock edges.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "rx_port_map.svh"

module rx_parallel_output_interface
   import rx_port_pkg::*;
(
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link clocks
   input wire logic recovered_clk,
   input wire logic reference_clock,
   // Received character, on the selected interface clock
   input wire logic [9:0] raw_char,
   input wire logic raw_is_comma,
   input wire logic [7:0] dec_data,
   input wire logic [2:0] dec_status,
   // Framer boundary request, on the recovered clock
   input wire logic align_request,
   input wire logic [3:0] align_offset,
   // Asynchronous reframe pin
   input wire logic reframe_enable,
   // Parallel outputs
   output logic [7:0] rx_data_bus,
   output logic [2:0] rx_status_bus,
   output logic rx_odd_parity_out,
   output logic rx_odd_parity_oe,
   // Clock outputs
   output logic rx_char_clock_pair_true,
   output logic rx_char_clock_pair_comp,
   output logic rx_char_clock_pair_oe,
   output logic rx_delayed_ref_clock,
   output logic rx_delayed_ref_oe,
   // Framer control
   output logic framer_enable,
   output logic [1:0] framing_mode,
   output logic [1:0] framing_char,
   output logic [3:0] char_boundary
);

   // ---------------- APB domain ----------------
   logic [`RXP_CTRL_WIDTH-1:0] ctrl_q;
   logic [`RXP_CTRL_WIDTH-1:0] ctrl_d;
   cfg_state_type cfg_state_q;
   cfg_state_type cfg_state_d;
   logic cfg_req_q;
   logic ack_meta_q;
   logic ack_sync_q;
   logic [2:0] stat_meta_q;
   logic [2:0] stat_sync_q;
   logic oack_meta_q;
   logic oack_sync_q;
   // Flops of the other domains that this domain synchronises
   logic link_ack_q;
   logic link_ref_mode_q;
   logic link_half_q;
   logic reframe_sync_q;
   logic oreq_seen_q;

   wire hit_ctrl = (paddr == `RXP_CTRL_OFFSET);
   wire hit_status = (paddr == `RXP_STATUS_OFFSET);
   wire mapped = hit_ctrl | hit_status;
   wire access = psel & penable;
   // A control write waits while the previous word is still in flight, so
   // the link side never captures a half-changed word.
   wire cfg_busy = (cfg_state_q != CFG_IDLE);
   wire wr_stall = pwrite & hit_ctrl & cfg_busy;
   wire wr_ctrl = access & pwrite & hit_ctrl & ~cfg_busy;
   // Done only once both the link and the output register hold the word;
   // the output side may run on a different clock from the link side.
   wire cfg_acked = (ack_sync_q == cfg_req_q) & (oack_sync_q == cfg_req_q);

   assign pready = ~wr_stall;
   assign pslverr = access & ~mapped;
   assign prdata = hit_ctrl ? {{(32-`RXP_CTRL_WIDTH){1'b0}}, ctrl_q} :
                   hit_status ? {29'h0000000, stat_sync_q} : 32'h00000000;
   assign ctrl_d = wr_ctrl ? pwdata[`RXP_CTRL_WIDTH-1:0] : ctrl_q;

   always_comb
   begin
      cfg_state_d = cfg_state_q;
      case (cfg_state_q)
         CFG_IDLE:
         begin
            if (wr_ctrl)
            begin
               cfg_state_d = CFG_SEND;
            end
         end
         CFG_SEND:
         begin
            cfg_state_d = CFG_WAIT;
         end
         CFG_WAIT:
         begin
            if (cfg_acked)
            begin
               cfg_state_d = CFG_IDLE;
            end
         end
         default:
         begin
            cfg_state_d = CFG_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= `RXP_CTRL_RESET;
         cfg_state_q <= CFG_IDLE;
         cfg_req_q <= 1'b0;
         ack_meta_q <= 1'b0;
         ack_sync_q <= 1'b0;
         oack_meta_q <= 1'b0;
         oack_sync_q <= 1'b0;
         stat_meta_q <= 3'h0;
         stat_sync_q <= 3'h0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         cfg_state_q <= cfg_state_d;
         if (cfg_state_q == CFG_SEND)
         begin
            cfg_req_q <= ~cfg_req_q;
         end
         ack_meta_q <= link_ack_q;
         ack_sync_q <= ack_meta_q;
         oack_meta_q <= oreq_seen_q;
         oack_sync_q <= oack_meta_q;
         // Status bits are independent and quasi-static; no word is formed
         stat_meta_q <= {link_half_q, link_ref_mode_q, reframe_sync_q};
         stat_sync_q <= stat_meta_q;
      end
   end

   // ---------------- Recovered clock domain ----------------
   logic link_rst_meta_q;
   logic link_rst_n_q;
   logic req_meta_q;
   logic req_sync_q;
   logic [`RXP_CTRL_WIDTH-1:0] link_cfg_q;
   logic reframe_enable_meta_q;
   logic half_clk_q;
   logic [3:0] boundary_q;

   // Link and output domains leave reset on their own clock, two edges after release
   always_ff @(posedge recovered_clk or negedge presetn)
   begin
      if (!presetn)
      begin
         link_rst_meta_q <= 1'b0;
         link_rst_n_q <= 1'b0;
      end
      else
      begin
         link_rst_meta_q <= 1'b1;
         link_rst_n_q <= link_rst_meta_q;
      end
   end

   wire [1:0] cfg_clksrc =
      link_cfg_q[`RXP_CTRL_CLKSRC_LSB+1:`RXP_CTRL_CLKSRC_LSB];
   wire new_cfg = (req_sync_q != link_ack_q);

   // Word is stable in ctrl_q while the request toggle is in flight
   always_ff @(posedge recovered_clk or negedge link_rst_n_q)
   begin
      if (!link_rst_n_q)
      begin
         req_meta_q <= 1'b0;
         req_sync_q <= 1'b0;
         link_ack_q <= 1'b0;
         link_cfg_q <= `RXP_CTRL_RESET;
      end
      else
      begin
         req_meta_q <= cfg_req_q;
         req_sync_q <= req_meta_q;
         if (new_cfg)
         begin
            link_cfg_q <= ctrl_q;
            link_ack_q <= req_sync_q;
         end
      end
   end

   // Clock mode and reframe gate
   always_ff @(posedge recovered_clk or negedge link_rst_n_q)
   begin
      if (!link_rst_n_q)
      begin
         link_ref_mode_q <= 1'b0;
         link_half_q <= 1'b0;
         reframe_enable_meta_q <= 1'b0;
         reframe_sync_q <= 1'b0;
         half_clk_q <= 1'b0;
         boundary_q <= 4'h0;
      end
      else
      begin
         link_ref_mode_q <= (cfg_clksrc == `RXP_LEVEL_LOW);
         link_half_q <= link_cfg_q[`RXP_CTRL_RX_CLOCK_RATE_SELECT_BIT];
         reframe_enable_meta_q <= reframe_enable;
         reframe_sync_q <= reframe_enable_meta_q;
         half_clk_q <= ~half_clk_q;
         if (reframe_sync_q && align_request)
         begin
            boundary_q <= align_offset;
         end
      end
   end

   assign framer_enable = reframe_sync_q;
   assign framing_mode =
      link_cfg_q[`RXP_CTRL_RFMODE_LSB+1:`RXP_CTRL_RFMODE_LSB];
   assign framing_char =
      link_cfg_q[`RXP_CTRL_FRAMCHAR_LSB+1:`RXP_CTRL_FRAMCHAR_LSB];
   assign char_boundary = boundary_q;

   // ---------------- Interface clock selection ----------------
   // Rate select only matters for the recovered clock; the reference
   // clock is passed through untouched.
   wire rec_if_clk = link_half_q ? half_clk_q : recovered_clk;
   // A source change can glitch this clock, so the select is treated
   // as static: change it only while the host ignores the port.
   wire sel_clk = link_ref_mode_q ? reference_clock : recovered_clk;

   assign rx_char_clock_pair_true =
      link_ref_mode_q ? reference_clock : rec_if_clk;
   assign rx_char_clock_pair_comp = ~rx_char_clock_pair_true;
   assign rx_char_clock_pair_oe = 1'b1;
   // Phase offset comes from the pad buffer, not from this logic
   assign rx_delayed_ref_clock = link_ref_mode_q & reference_clock;
   assign rx_delayed_ref_oe = link_ref_mode_q;

   // ---------------- Output register domain ----------------
   // Clocked by the selected interface clock; the mode select is static
   // in use, so software changes it only with the link quiet.
   logic out_rst_meta_q;
   logic out_rst_n_q;
   logic oreq_meta_q;
   logic oreq_sync_q;
   logic [`RXP_CTRL_WIDTH-1:0] out_cfg_q;
   logic [7:0] data_pos_q;
   logic [2:0] status_pos_q;
   logic parity_pos_q;
   logic [7:0] data_neg_q;
   logic [2:0] status_neg_q;
   logic parity_neg_q;

   // In reset the selected clock is the recovered clock
   always_ff @(posedge sel_clk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_rst_meta_q <= 1'b0;
         out_rst_n_q <= 1'b0;
      end
      else
      begin
         out_rst_meta_q <= 1'b1;
         out_rst_n_q <= out_rst_meta_q;
      end
   end

   always_ff @(posedge sel_clk or negedge out_rst_n_q)
   begin
      if (!out_rst_n_q)
      begin
         oreq_meta_q <= 1'b0;
         oreq_sync_q <= 1'b0;
         oreq_seen_q <= 1'b0;
         out_cfg_q <= `RXP_CTRL_RESET;
      end
      else
      begin
         oreq_meta_q <= cfg_req_q;
         oreq_sync_q <= oreq_meta_q;
         if (oreq_sync_q != oreq_seen_q)
         begin
            out_cfg_q <= ctrl_q;
            oreq_seen_q <= oreq_sync_q;
         end
      end
   end

   wire [1:0] dec_mode =
      out_cfg_q[`RXP_CTRL_DECODER_LSB+1:`RXP_CTRL_DECODER_LSB];
   wire [1:0] par_ctl =
      out_cfg_q[`RXP_CTRL_PARITY_LSB+1:`RXP_CTRL_PARITY_LSB];
   wire bypass = (dec_mode == `RXP_LEVEL_LOW);
   wire [7:0] data_d = bypass ? raw_char[9:2] : dec_data;
   wire [2:0] status_d = bypass ? {raw_is_comma, raw_char[1:0]}
                                : dec_status;
   // Parity is registered with the data it covers so the two never skew
   wire parity_d = ~(^data_d);
   wire both_edges = link_ref_mode_q & out_cfg_q[`RXP_CTRL_TX_CLOCK_RATE_SELECT_BIT];

   always_ff @(posedge sel_clk or negedge out_rst_n_q)
   begin
      if (!out_rst_n_q)
      begin
         data_pos_q <= 8'h00;
         status_pos_q <= 3'h0;
         parity_pos_q <= 1'b1;
      end
      else
      begin
         data_pos_q <= data_d;
         status_pos_q <= status_d;
         parity_pos_q <= parity_d;
      end
   end

   // Second bank for half-rate reference clocking
   always_ff @(negedge sel_clk or negedge out_rst_n_q)
   begin
      if (!out_rst_n_q)
      begin
         data_neg_q <= 8'h00;
         status_neg_q <= 3'h0;
         parity_neg_q <= 1'b1;
      end
      else
      begin
         data_neg_q <= data_d;
         status_neg_q <= status_d;
         parity_neg_q <= parity_d;
      end
   end

   // Low phase of a half-rate reference shows the falling-edge bank
   wire show_neg = both_edges & ~sel_clk;
   assign rx_data_bus = show_neg ? data_neg_q : data_pos_q;
   assign rx_status_bus = show_neg ? status_neg_q : status_pos_q;
   assign rx_odd_parity_out = show_neg ? parity_neg_q : parity_pos_q;
   assign rx_odd_parity_oe = (par_ctl != `RXP_LEVEL_LOW);

endmodule : rx_parallel_output_interface

`default_nettype wire

// [design/rx_port_map.svh]
// Register offsets, field positions, reset values and codes of the rx port
`ifndef RX_PORT_MAP_SVH
`define RX_PORT_MAP_SVH

`define RXP_CTRL_OFFSET 8'h00
`define RXP_STATUS_OFFSET 8'h04

`define RXP_CTRL_DECODER_LSB 0
`define RXP_CTRL_PARITY_LSB 2
`define RXP_CTRL_CLKSRC_LSB 4
`define RXP_CTRL_RX_CLOCK_RATE_SELECT_BIT 6
`define RXP_CTRL_TX_CLOCK_RATE_SELECT_BIT 7
`define RXP_CTRL_RFMODE_LSB 8
`define RXP_CTRL_FRAMCHAR_LSB 10
`define RXP_CTRL_WIDTH 12

`define RXP_STATUS_REFRAME_BIT 0
`define RXP_STATUS_REFMODE_BIT 1
`define RXP_STATUS_HALFRATE_BIT 2

// Decoder MID, parity LOW, recovered clock (MID), character rate
`define RXP_CTRL_RESET 12'h911

`define RXP_LEVEL_LOW 2'h0
`define RXP_LEVEL_MID 2'h1
`define RXP_LEVEL_HIGH 2'h2

`endif

// [design/rx_port_pkg.sv]
// Types shared by the receive parallel output port
package rx_port_pkg;

   typedef enum logic [1:0]
   {
      LEVEL_LOW = 2'h0,
      LEVEL_MID = 2'h1,
      LEVEL_HIGH = 2'h2,
      LEVEL_RSVD = 2'h3
   } level_type;

   // Gray coded along idle -> send -> wait
   typedef enum logic [1:0]
   {
      CFG_IDLE = 2'h0,
      CFG_SEND = 2'h1,
      CFG_WAIT = 2'h3
   } cfg_state_type;

endpackage : rx_port_pkg

// [tb/rx_host_model.sv]
// Host logic latching the receive port on the interface clocks
`timescale 1ns/100ps
`default_nettype none
module rx_host_model (
   // Interface clocks
   input wire logic clk_true, clk_comp, half_rate,
   // Port outputs and latched copies
   input wire logic [7:0] data,
   input wire logic [2:0] status,
   output logic [7:0] got_data,
   output logic [2:0] got_status
);
   // At half rate the complement rise carries every other character
   always @(posedge clk_true or posedge clk_comp)
   begin
      if (clk_true || half_rate)
      begin
         got_data <= data;
         got_status <= status;
      end
   end
endmodule : rx_host_model
`default_nettype wire

// [tb/rx_port_properties.sv]
// Checker on the rx port pins
`timescale 1ns/100ps
`default_nettype none
module rx_port_properties (
   // APB
   input wire logic pclk, presetn, psel, penable, pslverr,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   // Link
   input wire logic recovered_clk, reframe_enable, framer_enable,
   input wire logic [3:0] char_boundary,
   input wire logic [7:0] rx_data_bus,
   input wire logic rx_odd_parity_out, rx_odd_parity_oe,
   input wire logic rx_char_clock_pair_true, rx_char_clock_pair_comp,
   input wire logic rx_char_clock_pair_oe,
   input wire logic rx_delayed_ref_clock, rx_delayed_ref_oe
);
   wire logic bad_addr = paddr != 8'h00 && paddr != 8'h04;

   a_unmapped_err: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable && bad_addr |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_parity_odd: assert property (
      @(posedge pclk) disable iff (!presetn)
      rx_odd_parity_oe |-> ^{rx_data_bus, rx_odd_parity_out})
      else $error("parity not odd");
   a_pair_compl: assert property (
      @(posedge pclk) disable iff (!presetn)
      rx_char_clock_pair_comp != rx_char_clock_pair_true)
      else $error("clock pair not complementary");
   a_pair_driven: assert property (
      @(posedge pclk) disable iff (!presetn) rx_char_clock_pair_oe)
      else $error("clock pair not driven");
   a_dly_ref_copy: assert property (
      @(posedge pclk) disable iff (!presetn)
      rx_delayed_ref_oe |-> rx_delayed_ref_clock == rx_char_clock_pair_true)
      else $error("delayed clock not a reference copy");
   // Boundary at an edge is governed by the enable sampled at that edge
   a_boundary_hold: assert property (
      @(posedge recovered_clk) disable iff (!presetn)
      !framer_enable |=> $stable(char_boundary))
      else $error("boundary moved while framer off");
   a_framer_on: assert property (
      @(posedge recovered_clk) disable iff (!presetn)
      reframe_enable [*3] |=> framer_enable)
      else $error("framer not enabled");
   a_framer_off: assert property (
      @(posedge recovered_clk) disable iff (!presetn)
      !reframe_enable [*3] |=> !framer_enable)
      else $error("framer not disabled");
endmodule : rx_port_properties
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the receive parallel output port
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, dec_data = 8'h00, rx_data_bus, host_data;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic recovered_clk = 0, reference_clock = 0, raw_is_comma = 0;
   logic align_request = 0, reframe_enable = 0;
   logic [9:0] raw_char = 10'h000;
   logic [2:0] dec_status = 3'h0, rx_status_bus, host_status;
   logic [3:0] align_offset = 4'h0, char_boundary;
   logic pready, pslverr, err, rx_odd_parity_out, rx_odd_parity_oe;
   logic rx_char_clock_pair_true, rx_char_clock_pair_comp;
   logic rx_char_clock_pair_oe, rx_delayed_ref_clock, rx_delayed_ref_oe;
   logic framer_enable;
   logic [1:0] framing_mode, framing_char;
   logic [7:0] s;
   int num_errors = 0;
   int n_tests = 0;

   initial forever #10 pclk = ~pclk;
   initial forever #80 recovered_clk = ~recovered_clk;
   initial
   begin
      #13;
      forever #60 reference_clock = ~reference_clock;
   end

   rx_parallel_output_interface dut_u (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .recovered_clk,
      .reference_clock, .raw_char, .raw_is_comma, .dec_data, .dec_status,
      .align_request, .align_offset, .reframe_enable, .rx_data_bus,
      .rx_status_bus, .rx_odd_parity_out, .rx_odd_parity_oe,
      .rx_char_clock_pair_true, .rx_char_clock_pair_comp,
      .rx_char_clock_pair_oe, .rx_delayed_ref_clock, .rx_delayed_ref_oe,
      .framer_enable, .framing_mode, .framing_char, .char_boundary);

   rx_host_model host_u (.clk_true(rx_char_clock_pair_true),
      .clk_comp(rx_char_clock_pair_comp), .half_rate(1'h0),
      .data(rx_data_bus), .status(rx_status_bus), .got_data(host_data),
      .got_status(host_status));

   task test_done;
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      // Values read right at the edge are those the edge samples
      @(posedge pclk);
      while (pready !== 1'h1 && k < 50)
      begin
         k++;
         @(posedge pclk);
      end
      chk(pready, 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task cfg(input logic [11:0] v);
      apb(1'h1, 8'h00, {20'h0, v});
      repeat (6) @(negedge recovered_clk);
   endtask : cfg

   task feed(input logic [9:0] r, input logic c, input logic [7:0] d);
      @(posedge pclk);
      raw_char <= r;
      raw_is_comma <= c;
      dec_data <= d;
      dec_status <= d[2:0];
      repeat (4) @(negedge recovered_clk);
   endtask : feed

   task pairs(input logic use_ref);
      for (int i = 0; i < 8; i++)
      begin
         if (use_ref)
            @(posedge reference_clock);
         else
            @(posedge recovered_clk);
         #1 s[i] = rx_char_clock_pair_true;
      end
   endtask : pairs

   task align(input logic [3:0] o);
      @(posedge recovered_clk);
      align_request <= 1'h1;
      align_offset <= o;
      @(posedge recovered_clk);
      align_request <= 1'h0;
      repeat (2) @(negedge recovered_clk);
   endtask : align

   task t_regs;
      apb(1'h0, 8'h00, 32'h0);
      chk(rd, 32'h911);
      apb(1'h1, 8'h0c, 32'hffff);
      chk(err, 1'h1);
      apb(1'h0, 8'h04, 32'h0);
      chk(rd, 32'h0);
   endtask : t_regs

   task t_bypass;
      logic [9:0] r;
      r = 10'h2c5;
      cfg(12'h014);
      for (int i = 0; i < 4; i++)
      begin
         feed(r, i[0], 8'h00);
         chk(rx_data_bus, r[9:2]);
         chk(rx_status_bus, {i[0], r[1:0]});
         chk(rx_odd_parity_out, ~^r[9:2]);
         chk(host_data, r[9:2]);
         r = r + 10'h0a3;
      end
      for (logic [1:0] m = 2'h1; m < 2'h3; m++)
      begin
         cfg({10'h005, m});
         feed(10'h3ff, 1'h1, {6'h16, m});
         chk(rx_data_bus, {6'h16, m});
         chk(rx_status_bus, {1'h0, m});
      end
      for (logic [2:0] p = 3'h0; p < 3'h4; p++)
      begin
         cfg({8'h01, p[1:0], 2'h1});
         chk(rx_odd_parity_oe, p != 3'h0);
      end
   endtask : t_bypass

   task t_clocks;
      cfg(12'h014);
      pairs(1'h0);
      chk(s, 8'hff);
      chk(rx_delayed_ref_oe, 1'h0);
      cfg(12'h054);
      pairs(1'h0);
      chk(s[7:1] ^ s[6:0], 7'h7f);
      for (int k = 0; k < 2; k++)
      begin
         cfg({5'h00, k[0], 6'h04});
         pairs(1'h1);
         chk(s, 8'hff);
         chk(rx_delayed_ref_oe, 1'h1);
         feed(10'h1e4, 1'h0, 8'h00);
         chk(rx_data_bus, 8'h79);
      end
   endtask : t_clocks

   task t_both_edges;
      cfg(12'h084);
      @(posedge reference_clock);
      raw_char <= 10'h2a8;
      @(negedge reference_clock);
      #1;
      chk(rx_data_bus, 8'haa);
      @(posedge reference_clock);
      raw_char <= 10'h154;
      #1;
      chk(rx_data_bus, 8'haa);
      @(negedge reference_clock);
      #1;
      chk(rx_data_bus, 8'h55);
   endtask : t_both_edges

   task t_reframe;
      cfg(12'h611);
      chk(framing_mode, 2'h2);
      chk(framing_char, 2'h1);
      @(posedge pclk);
      reframe_enable <= 1'h1;
      repeat (4) @(negedge recovered_clk);
      chk(framer_enable, 1'h1);
      align(4'h5);
      chk(char_boundary, 4'h5);
      apb(1'h0, 8'h04, 32'h0);
      chk(rd, 32'h1);
      @(posedge pclk);
      reframe_enable <= 1'h0;
      repeat (4) @(negedge recovered_clk);
      align(4'h9);
      chk(char_boundary, 4'h5);
   endtask : t_reframe

   initial
   begin
      fork
         repeat (20) @(posedge pclk);
         repeat (3) @(posedge recovered_clk);
      join
      @(posedge pclk);
      presetn <= 1'h1;
      t_regs;
      t_bypass;
      t_clocks;
      t_both_edges;
      t_reframe;
      test_done;
   end

   initial
   begin
      #300000;
      num_errors++;
      $display("Error %0t: timeout", $time);
      test_done;
   end
endmodule : testbench

bind rx_parallel_output_interface rx_port_properties chk_u (.pclk,
   .presetn, .psel, .penable, .pslverr, .paddr, .prdata, .recovered_clk,
   .reframe_enable, .framer_enable, .char_boundary, .rx_data_bus,
   .rx_odd_parity_out, .rx_odd_parity_oe, .rx_char_clock_pair_true,
   .rx_char_clock_pair_comp, .rx_char_clock_pair_oe,
   .rx_delayed_ref_clock, .rx_delayed_ref_oe);
`default_nettype wire
